// file: rtl/iftp_trap_top.sv
// instruction fetch address trap with shared watchdog control registers
`timescale 1ns/1ps

// How it works
// - trap control bits live in the two watchdog control registers.
// - a new ram trap selection acts only after the code d2 is written.
// - code 4e clears the watchdog binary counter.
// - code b1 disables the watchdog; any other code only sets the bad-code event bit.
// - with ram trap selection 0 ram fetches pass, with 1 they trap.
// - every fetch from the special function area traps, except while the trap reset is active.
// - the trap action bit picks interrupt or reset as the trap result.
// - with trap action 0 a trapping fetch raises the trap interrupt.
// - the trap interrupt is non-maskable, whatever the master flag.
// - a trap during another service is taken at once, the other waits.
// - with trap action 1 a trapping fetch resets internal hardware.
// - the trap reset lasts at most 24 fast clock periods.
// - in low-speed mode one the fast oscillator restarts for the reset.
// - the first control register is write-only and reads as zero.
// - the disable code acts only when the watchdog enable bit is 0.
module iftp_trap_top (
   input  wire logic                hclk,                   // system clock
   input  wire logic                hresetn,                // reset, low
   input  wire logic                hsel,                   // slave select
   input  wire logic [31:0]         haddr,                  // byte address
   input  wire logic [1:0]          htrans,                 // transfer type
   input  wire logic                hwrite,                 // write
   input  wire logic [2:0]          hsize,                  // transfer size
   input  wire logic                hready,                 // bus ready
   input  wire logic [31:0]         hwdata,                 // write data
   output logic [31:0]              hrdata,                 // read data
   output logic                     hreadyout,              // slave ready
   output logic                     hresp,                  // response
   input  iftp_pkg::iftp_fetch_s    fetch,                  // cpu fetch
   input  wire logic                low_speed_mode_one,     // slow mode
   output logic                     fetch_trap,             // abort fetch
   output logic                     trap_interrupt_request, // nmi pulse
   output logic                     trap_hw_reset,          // hw reset
   output logic                     hf_osc_restart,         // osc restart
   output logic                     wdt_clear,              // clear pulse
   output logic                     watchdog_enabled,       // wdt runs
   output logic [1:0]               wdt_time,               // wdt period
   output logic                     wdt_output_select,      // wdt action
   output logic                     irq                     // event irq
);

   // ==========================================================================
   // helpers
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic is_wr(input iftp_pkg::iftp_reg_acc_s ac,
                                  input logic [7:0] idx);
      is_wr = ac.wr && (ac.idx == idx);
   endfunction

   // ==========================================================================
   // state
   typedef struct packed {
      logic [7:0]               ctrl;
      logic                     ram_trap_active;
      logic                     wdt_running;
      logic                     wdt_clr;
      logic                     nmi;
      logic [iftp_pkg::EV_W-1:0] status;
      logic [iftp_pkg::EV_W-1:0] mask;
   } iftp_top_s;

   iftp_top_s                 s;
   iftp_top_s                 next_s;
   iftp_pkg::iftp_reg_acc_s   acc;
   logic [31:0]               rd_value;
   logic                      rst_busy;
   logic                      in_sfr;
   logic                      in_ram;
   logic                      hit;
   logic                      trap_act;
   logic [7:0]                code;
   logic [iftp_pkg::EV_W-1:0] ev_set;
   logic [iftp_pkg::EV_W-1:0] ev_clr;

   // ==========================================================================
   // bus slave
   iftp_ahb_port u_port (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hwdata    (hwdata),
      .rd_value  (rd_value),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .acc       (acc)
   );

   // ==========================================================================
   // fetch check
   assign trap_act = s.ctrl[iftp_pkg::BIT_TRAP_ACT];
   assign in_sfr   = in_range(fetch.addr, iftp_pkg::SFR_LO, iftp_pkg::SFR_HI);
   assign in_ram   = in_range(fetch.addr, iftp_pkg::RAM_LO, iftp_pkg::RAM_HI);
   // fetches are ignored while the trap reset holds the hardware
   assign hit = fetch.valid && !rst_busy &&
                (in_sfr || (in_ram && s.ram_trap_active));
   // combinational so the cpu drops the opcode in the same cycle
   assign fetch_trap = hit;

   iftp_reset_timer u_timer (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .start      (hit && trap_act),
      .low_speed  (low_speed_mode_one),
      .busy       (rst_busy),
      .hf_restart (hf_osc_restart)
   );

   // ==========================================================================
   // register logic
   assign code = acc.wdata[7:0];

   always_comb begin
      next_s = s;
      next_s.wdt_clr = 1'b0;
      ev_set = '0;
      ev_clr = '0;
      // no mask, master flag or nesting state gates the trap interrupt
      next_s.nmi = hit && !trap_act;
      ev_set[iftp_pkg::EV_TRAP_IRQ] = hit && !trap_act;
      ev_set[iftp_pkg::EV_TRAP_RST] = hit && trap_act;
      if (is_wr(acc, iftp_pkg::IDX_CTRL)) begin
         next_s.ctrl = code;
         // watchdog output select can be cleared but never set again
         next_s.ctrl[iftp_pkg::BIT_WDT_OUT] =
            s.ctrl[iftp_pkg::BIT_WDT_OUT] && code[iftp_pkg::BIT_WDT_OUT];
         if (code[iftp_pkg::BIT_WDT_EN]) begin
            next_s.wdt_running = 1'b1;
         end
      end else if (is_wr(acc, iftp_pkg::IDX_CODE)) begin
         if (code == iftp_pkg::CODE_TRAP_COMMIT) begin
            next_s.ram_trap_active = s.ctrl[iftp_pkg::BIT_RAM_TRAP];
         end else if (code == iftp_pkg::CODE_WDT_CLEAR) begin
            next_s.wdt_clr = 1'b1;
         end else if (code == iftp_pkg::CODE_WDT_DISABLE) begin
            if (!s.ctrl[iftp_pkg::BIT_WDT_EN]) begin
               next_s.wdt_running = 1'b0;
            end
         end else begin
            ev_set[iftp_pkg::EV_BAD_CODE] = 1'b1;
         end
      end else if (is_wr(acc, iftp_pkg::IDX_STATUS)) begin
         ev_clr = acc.wdata[iftp_pkg::EV_W-1:0];
      end else if (is_wr(acc, iftp_pkg::IDX_MASK)) begin
         next_s.mask = acc.wdata[iftp_pkg::EV_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      next_s.status = (s.status & ~ev_clr) | ev_set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{ctrl:            iftp_pkg::CTRL_RESET,
                ram_trap_active: iftp_pkg::RAM_TRAP_RESET,
                wdt_running:     1'b1,
                wdt_clr:         1'b0,
                nmi:             1'b0,
                status:          '0,
                mask:            '0};
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================================
   // read mux
   always_comb begin
      rd_value = '0;
      if (acc.idx == iftp_pkg::IDX_STATUS) begin
         rd_value[iftp_pkg::EV_W-1:0] = s.status;
      end else if (acc.idx == iftp_pkg::IDX_MASK) begin
         rd_value[iftp_pkg::EV_W-1:0] = s.mask;
      end else if (acc.idx == iftp_pkg::IDX_STATE) begin
         rd_value[5:0] = {hf_osc_restart, rst_busy, s.wdt_running,
                          trap_act, s.ram_trap_active,
                          s.ctrl[iftp_pkg::BIT_RAM_TRAP]};
      end
      // both code registers are write-only and read back as zero
   end

   // ==========================================================================
   // outputs
   assign trap_interrupt_request = s.nmi;
   assign trap_hw_reset          = rst_busy;
   assign wdt_clear              = s.wdt_clr;
   assign watchdog_enabled       = s.wdt_running;
   assign wdt_time = s.ctrl[iftp_pkg::BIT_WDT_T_HI:iftp_pkg::BIT_WDT_T_LO];
   assign wdt_output_select      = s.ctrl[iftp_pkg::BIT_WDT_OUT];
   assign irq                    = |(s.status & s.mask);

   // ==========================================================================
   // checks
   sequence s_code_write(logic [7:0] c);
      acc.wr && (acc.idx == iftp_pkg::IDX_CODE) && (code == c);
   endsequence

   sequence s_trap_fetch(logic act);
      fetch_trap && (trap_act == act);
   endsequence

   a_sfr_always_trap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (fetch.valid && in_sfr && !rst_busy) |-> fetch_trap)
      else $error("sfr fetch did not trap");

   a_ram_trap_sel: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (fetch.valid && in_ram && !rst_busy) |->
      (fetch_trap == s.ram_trap_active))
      else $error("ram fetch trap does not follow selection");

   a_commit_takes: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_code_write(iftp_pkg::CODE_TRAP_COMMIT) |=>
      (s.ram_trap_active == $past(s.ctrl[iftp_pkg::BIT_RAM_TRAP])))
      else $error("trap selection not committed");

   a_commit_needed: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !(acc.wr && acc.idx == iftp_pkg::IDX_CODE) |=>
      $stable(s.ram_trap_active))
      else $error("trap selection changed without commit");

   a_nmi_on_trap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_trap_fetch(1'b0) |=> trap_interrupt_request)
      else $error("trap interrupt missing");

   a_nmi_cause: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trap_interrupt_request |-> $past(fetch_trap && !trap_act))
      else $error("trap interrupt without trapping fetch");

   a_nmi_not_reset: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_trap_fetch(1'b0) |=> !trap_hw_reset)
      else $error("interrupt action started a reset");

   a_reset_on_trap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (fetch_trap && trap_act) |=> trap_hw_reset && !trap_interrupt_request)
      else $error("trap reset missing");

   a_wdt_clear_code: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_code_write(iftp_pkg::CODE_WDT_CLEAR) |=> wdt_clear ##1
      (!wdt_clear || $past(acc.wr && (acc.idx == iftp_pkg::IDX_CODE) &&
                           (code == iftp_pkg::CODE_WDT_CLEAR))))
      else $error("clear code did not pulse watchdog clear");

   a_disable_guard: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_code_write(iftp_pkg::CODE_WDT_DISABLE) ##0
      s.ctrl[iftp_pkg::BIT_WDT_EN] |=> $stable(watchdog_enabled))
      else $error("disable code acted while watchdog enable set");

   a_disable_works: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_code_write(iftp_pkg::CODE_WDT_DISABLE) ##0
      !s.ctrl[iftp_pkg::BIT_WDT_EN] |=> !watchdog_enabled)
      else $error("disable code ignored");

   a_ctrl_reads_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc.rd && acc.idx == iftp_pkg::IDX_CTRL) |-> rd_value == 32'h0000_0000)
      else $error("write-only register read back nonzero");

   a_reset_blanks_fetch: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trap_hw_reset |-> !fetch_trap)
      else $error("fetch trapped during trap reset");

   a_no_trap_outside: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (fetch.valid && !in_sfr && !in_ram) |-> !fetch_trap)
      else $error("fetch outside trap areas trapped");

   a_hf_only_slow: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_trap_fetch(1'b1) ##0 !low_speed_mode_one |=> !hf_osc_restart)
      else $error("oscillator restart outside low-speed mode");

   a_bad_code_inert: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc.wr && (acc.idx == iftp_pkg::IDX_CODE) &&
       (code != iftp_pkg::CODE_TRAP_COMMIT) &&
       (code != iftp_pkg::CODE_WDT_CLEAR) &&
       (code != iftp_pkg::CODE_WDT_DISABLE)) |=>
      ($stable(watchdog_enabled) && !wdt_clear &&
       $stable(s.ram_trap_active) && s.status[iftp_pkg::EV_BAD_CODE]))
      else $error("undefined code changed state");

endmodule // iftp_trap_top

// file: rtl/iftp_pkg.sv
// shared constants and carrier types of the instruction fetch address trap
package iftp_pkg;

   // ==========================================================================
   // clock and trap reset timing
   localparam int          CLK_MHZ         = 200;
   // longest trap reset: 24 high-frequency clock periods, 1500 ns at 16 MHz
   localparam int          RESET_TIME_NS   = 1500;
   // a longest time rounds down to whole cycles
   localparam int          RESET_CYCLES_I  = (RESET_TIME_NS * CLK_MHZ) / 1000;
   localparam logic [8:0]  RESET_CYCLES    = 9'(RESET_CYCLES_I);
   localparam logic [8:0]  CNT_ONE         = 9'h001;
   localparam logic [8:0]  CNT_ZERO        = 9'h000;

   // ==========================================================================
   // register indices; byte address is four times the index
   localparam int          IDX_W           = 8;
   localparam logic [7:0]  IDX_CTRL        = 8'h34;
   localparam logic [7:0]  IDX_CODE        = 8'h35;
   localparam logic [7:0]  IDX_STATUS      = 8'h36;
   localparam logic [7:0]  IDX_MASK        = 8'h37;
   localparam logic [7:0]  IDX_STATE       = 8'h38;
   localparam int          IDX_LSB         = 2;

   // ==========================================================================
   // control codes of watchdog_and_trap_code
   localparam logic [7:0]  CODE_TRAP_COMMIT = 8'hd2;
   localparam logic [7:0]  CODE_WDT_CLEAR   = 8'h4e;
   localparam logic [7:0]  CODE_WDT_DISABLE = 8'hb1;

   // ==========================================================================
   // watchdog_trap_control_first fields
   localparam int          BIT_RAM_TRAP    = 5;
   localparam int          BIT_TRAP_ACT    = 4;
   localparam int          BIT_WDT_EN      = 3;
   localparam int          BIT_WDT_T_HI    = 2;
   localparam int          BIT_WDT_T_LO    = 1;
   localparam int          BIT_WDT_OUT     = 0;
   localparam logic [7:0]  CTRL_RESET      = 8'h39;
   localparam logic        RAM_TRAP_RESET  = 1'b1;

   // ==========================================================================
   // fetch address map
   localparam logic [15:0] SFR_LO          = 16'h0000;
   localparam logic [15:0] SFR_HI          = 16'h003f;
   localparam logic [15:0] RAM_LO          = 16'h0040;
   localparam logic [15:0] RAM_HI          = 16'h013f;

   // ==========================================================================
   // event bits of the status and mask registers
   localparam int          EV_W            = 3;
   localparam int          EV_TRAP_IRQ     = 0;
   localparam int          EV_TRAP_RST     = 1;
   localparam int          EV_BAD_CODE     = 2;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } iftp_fetch_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  idx;
      logic [31:0] wdata;
   } iftp_reg_acc_s;

endpackage

// file: rtl/iftp_ahb_port.sv
// ahb-lite slave front end of the address trap registers
`timescale 1ns/1ps
module iftp_ahb_port (
   input  wire logic                  hclk,      // system clock
   input  wire logic                  hresetn,   // async reset, active low
   input  wire logic                  hsel,      // slave select
   input  wire logic [31:0]           haddr,     // byte address
   input  wire logic [1:0]            htrans,    // transfer type
   input  wire logic                  hwrite,    // write when high
   input  wire logic                  hready,    // bus ready
   input  wire logic [31:0]           hwdata,    // write data
   input  wire logic [31:0]           rd_value,  // read data from registers
   output logic                       hreadyout, // slave ready
   output logic                       hresp,     // always okay
   output logic [31:0]                hrdata,    // registered read data
   output iftp_pkg::iftp_reg_acc_s    acc        // register access strobe
);

   // ==========================================================================
   // state
   typedef struct packed {
      logic        wr_ph;
      logic        rd_ph;
      logic        rd_done;
      logic [7:0]  idx;
      logic [31:0] rdata;
   } iftp_port_s;

   iftp_port_s s;
   iftp_port_s next_s;

   // reads take one wait state so hrdata can come straight from a flop
   always_comb begin
      next_s = s;
      next_s.wr_ph = 1'b0;
      if (s.rd_ph && !s.rd_done) begin
         next_s.rdata   = rd_value;
         next_s.rd_done = 1'b1;
      end else begin
         next_s.rd_ph   = 1'b0;
         next_s.rd_done = 1'b0;
      end
      if (hsel && htrans[1] && hready) begin
         next_s.wr_ph   = hwrite;
         next_s.rd_ph   = !hwrite;
         next_s.rd_done = 1'b0;
         next_s.idx     = haddr[iftp_pkg::IDX_LSB +: iftp_pkg::IDX_W];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout = !(s.rd_ph && !s.rd_done);
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;
   assign acc.wr    = s.wr_ph;
   assign acc.rd    = s.rd_ph && !s.rd_done;
   assign acc.idx   = s.idx;
   assign acc.wdata = hwdata;

endmodule // iftp_ahb_port

// file: rtl/iftp_reset_timer.sv
// timer for the internal reset pulse raised by an address trap
`timescale 1ns/1ps
module iftp_reset_timer (
   input  wire logic hclk,       // system clock
   input  wire logic hresetn,    // async reset, active low
   input  wire logic start,      // one-cycle trap reset request
   input  wire logic low_speed,  // low-speed mode one at the request
   output logic      busy,       // internal reset active
   output logic      hf_restart  // high-frequency oscillator restart
);

   // ==========================================================================
   // state
   typedef enum logic [1:0] {
      TM_IDLE = 2'b01,
      TM_HOLD = 2'b10
   } iftp_tm_e;

   typedef struct packed {
      iftp_tm_e   st;
      logic [8:0] cnt;
      logic       slow;
   } iftp_tm_s;

   iftp_tm_s s;
   iftp_tm_s next_s;

   always_comb begin
      next_s = s;
      case (s.st)
         TM_IDLE: begin
            if (start) begin
               next_s.st   = TM_HOLD;
               next_s.cnt  = iftp_pkg::RESET_CYCLES - iftp_pkg::CNT_ONE;
               next_s.slow = low_speed;
            end
         end
         TM_HOLD: begin
            if (s.cnt == iftp_pkg::CNT_ZERO) begin
               next_s.st   = TM_IDLE;
               next_s.slow = 1'b0;
            end else begin
               next_s.cnt = s.cnt - iftp_pkg::CNT_ONE;
            end
         end
         default: begin
            next_s.st = TM_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{st: TM_IDLE, cnt: '0, slow: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign busy       = (s.st == TM_HOLD);
   // in low-speed mode the pulse is timed as on the restarted fast clock
   assign hf_restart = busy && s.slow;

   // ==========================================================================
   // checks
   logic [9:0] len;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         len <= '0;
      end else begin
         len <= busy ? len + 10'h001 : 10'h000;
      end
   end

   a_reset_len_max: assert property (
      @(posedge hclk) disable iff (!hresetn)
      len <= 10'(iftp_pkg::RESET_CYCLES))
      else $error("trap reset longer than allowed");

   a_slow_restart: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (start && !busy && low_speed) |=> hf_restart throughout busy[*8])
      else $error("oscillator restart missing in low-speed reset");

endmodule // iftp_reset_timer

// file: verif/iftp_cpu_model.sv
// cpu core model: fetches on request and nests trap interrupts
`timescale 1ns/1ps
module iftp_cpu_model (
   input  wire logic             hclk,    // system clock
   input  wire logic             hresetn, // reset, active low
   input  wire logic             run,     // fetch this cycle
   input  wire logic [15:0]      pc,      // fetch address
   input  wire logic             nmi,     // trap interrupt
   output iftp_pkg::iftp_fetch_s fetch,   // fetch request
   output logic [3:0]            depth    // nesting depth
);
   logic sp_ok;
   // no fetch until the stack pointer is set
   assign fetch = '{valid: run & sp_ok, addr: pc};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_ok <= 1'b0;
         depth <= 4'h0;
      end else begin
         sp_ok <= 1'b1;
         // taken whatever the master flag; the earlier one waits
         if (nmi) depth <= depth + 4'h1;
      end
   end
endmodule // iftp_cpu_model

// file: verif/instruction_fetch_address_trap_test.sv
// self-checking bench of the instruction fetch address trap
`timescale 1ns/1ps
module instruction_fetch_address_trap_test;
   typedef struct packed {
      logic [7:0]  c;
      logic        k;
      logic [15:0] a;
      logic        t;
   } iftp_row_s;
   logic                  hclk = 1'b0;
   logic                  hresetn = 1'b0;
   logic [31:0]           haddr = 32'h0;
   logic [1:0]            htrans = 2'h0;
   logic                  hwrite = 1'b0;
   logic [31:0]           hwdata = 32'h0;
   logic [31:0]           hrdata, q;
   logic                  hreadyout, hresp, run = 1'b0, lsm = 1'b0;
   logic [15:0]           pc = 16'h0;
   iftp_pkg::iftp_fetch_s fetch;
   logic                  ftrap, nmi, trst, osc, wclr, wen, irq, wo;
   logic [1:0]            wt;
   logic                  tf, tm, ts, os;
   logic [3:0]            depth, d0;
   int                    err_total = 0, samples_checked = 0, n, k;
   iftp_row_s rows [6] = '{'{8'h09, 1'b0, 16'h0040, 1'b1},
      '{8'h09, 1'b1, 16'h0040, 1'b0}, '{8'h09, 1'b1, 16'h0010, 1'b1},
      '{8'h29, 1'b0, 16'h013f, 1'b0}, '{8'h29, 1'b1, 16'h013f, 1'b1},
      '{8'h29, 1'b1, 16'h0140, 1'b0}};
   always #2.5 hclk = ~hclk;
   iftp_trap_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .fetch(fetch),
      .low_speed_mode_one(lsm), .fetch_trap(ftrap),
      .trap_interrupt_request(nmi), .trap_hw_reset(trst),
      .hf_osc_restart(osc), .wdt_clear(wclr), .watchdog_enabled(wen),
      .wdt_time(wt), .wdt_output_select(wo), .irq(irq));
   iftp_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .run(run),
      .pc(pc), .nmi(nmi), .fetch(fetch), .depth(depth));
   // ==========================================================================
   // checking and closing
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================================
   // ahb-lite master; ready and read data are taken at the rising edge
   task automatic wait_rdy();
      logic r;
      n = 0;
      do begin
         @(posedge hclk);
         r = hreadyout;
         q = hrdata;
         n++;
      end while (r !== 1'b1 && n < 50);
      if (r !== 1'b1) begin
         err_total++;
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, i, 2'h0};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   // one fetch cycle: trap seen in it, result seen in the next
   task automatic go(input logic [15:0] a);
      run <= 1'b1;
      pc <= a;
      @(negedge hclk);
      tf = ftrap;
      @(posedge hclk);
      run <= 1'b0;
      @(negedge hclk);
      tm = nmi;
      ts = trst;
      os = osc;
      @(posedge hclk);
   endtask
   // ==========================================================================
   // main sequence
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(wt, 2'h0);
      chk(wo, 1'b1);
      chk(wen, 1'b1);
      bus(1'b0, iftp_pkg::IDX_STATE, 32'h0);
      chk(q, 32'h0000000f);
      bus(1'b0, iftp_pkg::IDX_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      foreach (rows[i]) begin
         bus(1'b1, iftp_pkg::IDX_CTRL, {24'h0, rows[i].c});
         if (rows[i].k) bus(1'b1, iftp_pkg::IDX_CODE, 32'hd2);
         go(rows[i].a);
         chk(tf, rows[i].t);
         chk(tm, rows[i].t);
      end
      bus(1'b1, iftp_pkg::IDX_CODE, 32'h4e);
      @(posedge hclk);
      chk(wclr, 1'b1);
      @(posedge hclk);
      chk(wclr, 1'b0);
      bus(1'b1, iftp_pkg::IDX_CODE, 32'hb1);
      @(posedge hclk);
      chk(wen, 1'b1);
      bus(1'b1, iftp_pkg::IDX_CTRL, 32'h07);
      @(posedge hclk);
      chk(wen, 1'b1);
      chk(wt, 2'h3);
      bus(1'b1, iftp_pkg::IDX_CODE, 32'hb1);
      @(posedge hclk);
      chk(wen, 1'b0);
      bus(1'b1, iftp_pkg::IDX_STATUS, 32'h7);
      bus(1'b1, iftp_pkg::IDX_MASK, 32'h4);
      bus(1'b1, iftp_pkg::IDX_CODE, 32'h77);
      bus(1'b0, iftp_pkg::IDX_STATUS, 32'h0);
      chk(q, 32'h4);
      chk(hresp, 1'b0);
      chk(irq, 1'b1);
      bus(1'b1, iftp_pkg::IDX_MASK, 32'h0);
      @(posedge hclk);
      chk(irq, 1'b0);
      bus(1'b1, iftp_pkg::IDX_MASK, 32'h4);
      bus(1'b1, iftp_pkg::IDX_STATUS, 32'h4);
      @(posedge hclk);
      chk(irq, 1'b0);
      // back-to-back trapping fetches nest two interrupts
      bus(1'b1, iftp_pkg::IDX_CTRL, 32'h08);
      d0 = depth;
      run <= 1'b1;
      pc <= 16'h0020;
      repeat (2) @(posedge hclk);
      run <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(depth, d0 + 4'h2);
      bus(1'b1, iftp_pkg::IDX_CTRL, 32'h19);
      lsm <= 1'b1;
      go(16'h0010);
      chk(tf, 1'b1);
      chk(tm, 1'b0);
      chk(os, 1'b1);
      k = 0;
      repeat (400) begin
         @(negedge hclk);
         if (trst === 1'b1) k++;
      end
      chk(32'(k) + 32'(ts), 32'(iftp_pkg::RESET_CYCLES));
      chk(wo, 1'b0);
      // a mid-run reset brings back the reset selection
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, iftp_pkg::IDX_STATE, 32'h0);
      chk(q, 32'h0000000f);
      chk(wo, 1'b1);
      finish_test();
   end
endmodule // instruction_fetch_address_trap_test
